// file: rtl/dacs_defs.vh
// Register map, field positions, reset values and fixed counts of the dual converter settings block.
`ifndef DACS_DEFS_VH
`define DACS_DEFS_VH

// Register byte offsets.
`define DACS_OFF_CONFIG        12'h000
`define DACS_OFF_I_CHANNEL     12'h004
`define DACS_OFF_Q_CHANNEL     12'h008
`define DACS_OFF_ADJUST        12'h00C
`define DACS_OFF_SYNC          12'h010
`define DACS_OFF_COMMAND       12'h014
`define DACS_OFF_STATUS        12'h018

// Configuration register fields.
`define DACS_CFG_PHASE         0
`define DACS_CFG_SWING         1
`define DACS_CFG_PATTERN       2
`define DACS_CFG_PD_I          3
`define DACS_CFG_PD_Q          4
`define DACS_CFG_DES           5
`define DACS_CFG_DES_Q         6
`define DACS_CFG_DES_TIED      7
`define DACS_CFG_TWOS          8
`define DACS_CFG_NON_DEMUX     9
`define DACS_CFG_W             10
`define DACS_CFG_RESET         10'h000

// Channel register fields.
`define DACS_CH_OFS_LSB        0
`define DACS_CH_OFS_MSB        9
`define DACS_CH_SIGN           10
`define DACS_CH_FS_LSB         16
`define DACS_CH_FS_MSB         25
`define DACS_FS_MIN_MV         10'd600
`define DACS_FS_MAX_MV         10'd980
`define DACS_FS_RESET_MV       10'd790

// Adjust register fields.
`define DACS_ADJ_DCC           0
`define DACS_ADJ_STA           1
`define DACS_ADJ_SA            2
`define DACS_ADJ_COARSE_LSB    8
`define DACS_ADJ_COARSE_MSB    12
`define DACS_ADJ_FINE_LSB      16
`define DACS_ADJ_FINE_MSB      23
`define DACS_ADJ_LC_LSB        28
`define DACS_ADJ_LC_MSB        31

// Sync register fields.
`define DACS_SYN_DR            0
`define DACS_SYN_DOC           1
`define DACS_SYN_ES            2
`define DACS_SYN_PH_LSB        4
`define DACS_SYN_PH_MSB        5
`define DACS_SYN_DLY_LSB       16
`define DACS_SYN_DLY_MSB       25

// Command and status fields.
`define DACS_CMD_CAL           0
`define DACS_STS_CAL_REQ       0
`define DACS_STS_ECE           1
`define DACS_STS_FOLLOW        2
`define DACS_STS_PS_LSB        16
`define DACS_STS_PS_MSB        25

// Reference clock delay scaling.
`define DACS_DLY_TOP_CODE      10'd639
`define DACS_DLY_MAX_PS        20'd1000
`define DACS_DLY_TOP_CODE_W    20'd639

// Pin-mode control input width.
`define DACS_PIN_W             10

`endif

// file: rtl/dacs_top.v
// Dual converter control settings block with an AHB-Lite register slave.
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "dacs_defs.vh"

module dacs_top #(
  parameter [9:0] PATTERN_I = 10'h2AA,
  parameter [9:0] PATTERN_Q = 10'h155
) (
  // Clock and reset.
  input  wire        clk_in,
  input  wire        rst_b_in,
  // AHB-Lite slave.
  input  wire        hsel_in,
  input  wire [11:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire        hready_in,
  input  wire [31:0] hwdata_in,
  output reg  [31:0] hrdata_out,
  output reg         hreadyout_out,
  output reg         hresp_out,
  // Board pins.
  input  wire        extended_control_enable_in,
  input  wire        data_output_clock_reset_in,
  input  wire [9:0]  control_pins_in,
  // Converter core samples.
  input  wire [9:0]  sample_i_in,
  input  wire        overrange_i_in,
  input  wire [9:0]  sample_q_in,
  input  wire        overrange_q_in,
  // Output stage.
  output reg  [9:0]  data_i_out,
  output reg         overrange_i_out,
  output reg  [9:0]  data_q_out,
  output reg         overrange_q_out,
  output reg         data_clock_phase_select_out,
  output reg         output_swing_select_out,
  output reg         fixed_pattern_mode_out,
  output reg         data_output_clock_reset_out,
  // Analog front end.
  output reg         i_channel_powerdown_out,
  output reg         q_channel_powerdown_out,
  output reg         double_edge_sampling_out,
  output reg         interleave_from_q_input_out,
  output reg         interleave_inputs_tied_out,
  output reg  [9:0]  offset_i_out,
  output reg         offset_i_negative_out,
  output reg  [9:0]  offset_q_out,
  output reg         offset_q_negative_out,
  output reg  [9:0]  full_scale_i_mv_out,
  output reg  [9:0]  full_scale_q_mv_out,
  output reg         calibrate_start_out,
  // Clock tuning.
  output reg         duty_cycle_correction_out,
  output reg         aperture_delay_enable_out,
  output reg  [8:0]  aperture_delay_out,
  output reg         lc_filter_enable_out,
  output reg  [3:0]  lc_filter_tune_out,
  // Multi-device synchronisation.
  output reg         reference_clock_out_a,
  output reg         reference_clock_out_b,
  output reg         follower_sync_mode_out,
  output reg  [1:0]  follower_phase_select_out,
  output reg  [9:0]  reference_delay_ps_out
);

  // Settings registers.
  reg  [9:0]  config_r;
  reg  [9:0]  ofs_i_r;
  reg         sign_i_r;
  reg  [9:0]  fs_i_r;
  reg  [9:0]  ofs_q_r;
  reg         sign_q_r;
  reg  [9:0]  fs_q_r;
  reg         dcc_r;
  reg         sta_r;
  reg         sa_r;
  reg  [4:0]  coarse_r;
  reg  [7:0]  fine_r;
  reg  [3:0]  lc_r;
  reg         dr_r;
  reg         doc_r;
  reg         es_r;
  reg  [1:0]  phase_r;
  reg  [9:0]  dly_code_r;
  reg         cal_req_r;
  // Bus data-phase state.
  reg         wr_pend_r;
  reg  [11:0] wr_addr_r;
  // Pin synchronisers.
  reg  [11:0] pin_s1_r;
  reg  [11:0] pin_s2_r;
  reg  [11:0] pin_s3_r;
  reg  [11:0] pin_stable_r;
  reg         data_output_clock_rst_prev_r;
  // Quarter-rate divider.
  reg  [1:0]  div_r;

  wire        addr_phase;
  wire        wr_cfg;
  wire        wr_ich;
  wire        wr_qch;
  wire        wr_adj;
  wire        wr_syn;
  wire        wr_cmd;
  wire        ece;
  wire [9:0]  eff_cfg;
  wire [9:0]  fs_i_nxt;
  wire [9:0]  fs_q_nxt;
  wire [9:0]  dly_sat;
  wire [19:0] dly_prod;
  wire [19:0] dly_ps;
  wire        data_output_clock_rst_sync;
  reg  [31:0] rdata_nxt;

  // A transfer is taken when selected, the bus is ready and htrans is NONSEQ or SEQ.
  assign addr_phase = hsel_in & hready_in & htrans_in[1];

  // Writes land in the data phase, one cycle after the address was taken.
  assign wr_cfg = wr_pend_r & (wr_addr_r == `DACS_OFF_CONFIG);
  assign wr_ich = wr_pend_r & (wr_addr_r == `DACS_OFF_I_CHANNEL);
  assign wr_qch = wr_pend_r & (wr_addr_r == `DACS_OFF_Q_CHANNEL);
  assign wr_adj = wr_pend_r & (wr_addr_r == `DACS_OFF_ADJUST);
  assign wr_syn = wr_pend_r & (wr_addr_r == `DACS_OFF_SYNC);
  assign wr_cmd = wr_pend_r & (wr_addr_r == `DACS_OFF_COMMAND);

  // Full-scale writes are clamped into the legal range so the front end never sees a bad code.
  assign fs_i_nxt = (hwdata_in[`DACS_CH_FS_MSB:`DACS_CH_FS_LSB] < `DACS_FS_MIN_MV) ? `DACS_FS_MIN_MV :
                    (hwdata_in[`DACS_CH_FS_MSB:`DACS_CH_FS_LSB] > `DACS_FS_MAX_MV) ? `DACS_FS_MAX_MV :
                    hwdata_in[`DACS_CH_FS_MSB:`DACS_CH_FS_LSB];
  assign fs_q_nxt = (hwdata_in[`DACS_CH_FS_MSB:`DACS_CH_FS_LSB] < `DACS_FS_MIN_MV) ? `DACS_FS_MIN_MV :
                    (hwdata_in[`DACS_CH_FS_MSB:`DACS_CH_FS_LSB] > `DACS_FS_MAX_MV) ? `DACS_FS_MAX_MV :
                    hwdata_in[`DACS_CH_FS_MSB:`DACS_CH_FS_LSB];

  // Synchronised pin levels: bit 11 extended control, bit 10 data-clock reset, rest control pins.
  assign ece           = pin_stable_r[11];
  assign data_output_clock_rst_sync = pin_stable_r[10];
  assign eff_cfg       = ece ? config_r : pin_stable_r[9:0];

  // Reference delay saturates at the top code, then scales linearly to the maximum.
  assign dly_sat  = (dly_code_r > `DACS_DLY_TOP_CODE) ? `DACS_DLY_TOP_CODE : dly_code_r;
  assign dly_prod = {10'h000, dly_sat} * `DACS_DLY_MAX_PS;
  assign dly_ps   = dly_prod / `DACS_DLY_TOP_CODE_W;

  // Bus slave: zero wait states, always OKAY, read data registered at the address phase.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_pend_r     <= 1'b0;
      wr_addr_r     <= 12'h000;
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      wr_pend_r     <= addr_phase & hwrite_in;
      wr_addr_r     <= {haddr_in[11:2], 2'b00};
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      if (addr_phase & ~hwrite_in) begin
        hrdata_out <= rdata_nxt;
      end
    end
  end

  // Read mux; unmapped offsets and the command register read as zero.
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case ({haddr_in[11:2], 2'b00})
      `DACS_OFF_CONFIG: begin
        rdata_nxt[`DACS_CFG_W-1:0] = config_r;
      end
      `DACS_OFF_I_CHANNEL: begin
        rdata_nxt = {6'h00, fs_i_r, 5'h00, sign_i_r, ofs_i_r};
      end
      `DACS_OFF_Q_CHANNEL: begin
        rdata_nxt = {6'h00, fs_q_r, 5'h00, sign_q_r, ofs_q_r};
      end
      `DACS_OFF_ADJUST: begin
        rdata_nxt = {lc_r, 4'h0, fine_r, 3'h0, coarse_r, 5'h00, sa_r, sta_r, dcc_r};
      end
      `DACS_OFF_SYNC: begin
        rdata_nxt = {6'h00, dly_code_r, 10'h000, phase_r, 1'b0, es_r, doc_r, dr_r};
      end
      `DACS_OFF_STATUS: begin
        rdata_nxt = {6'h00, dly_ps[9:0], 13'h0000, es_r, ece, cal_req_r};
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Each register group changes only on a write to its own offset.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      config_r   <= `DACS_CFG_RESET;
      ofs_i_r    <= 10'h000;
      sign_i_r   <= 1'b0;
      fs_i_r     <= `DACS_FS_RESET_MV;
      ofs_q_r    <= 10'h000;
      sign_q_r   <= 1'b0;
      fs_q_r     <= `DACS_FS_RESET_MV;
      dcc_r      <= 1'b1;
      sta_r      <= 1'b0;
      sa_r       <= 1'b0;
      coarse_r   <= 5'h00;
      fine_r     <= 8'h00;
      lc_r       <= 4'h0;
      dr_r       <= 1'b1;
      doc_r      <= 1'b1;
      es_r       <= 1'b0;
      phase_r    <= 2'h0;
      dly_code_r <= 10'h000;
    end else begin
      if (wr_cfg) begin
        config_r <= hwdata_in[`DACS_CFG_W-1:0];
      end
      if (wr_ich) begin
        ofs_i_r  <= hwdata_in[`DACS_CH_OFS_MSB:`DACS_CH_OFS_LSB];
        sign_i_r <= hwdata_in[`DACS_CH_SIGN];
        fs_i_r   <= fs_i_nxt;
      end
      if (wr_qch) begin
        ofs_q_r  <= hwdata_in[`DACS_CH_OFS_MSB:`DACS_CH_OFS_LSB];
        sign_q_r <= hwdata_in[`DACS_CH_SIGN];
        fs_q_r   <= fs_q_nxt;
      end
      if (wr_adj) begin
        dcc_r    <= hwdata_in[`DACS_ADJ_DCC];
        sta_r    <= hwdata_in[`DACS_ADJ_STA];
        sa_r     <= hwdata_in[`DACS_ADJ_SA];
        coarse_r <= hwdata_in[`DACS_ADJ_COARSE_MSB:`DACS_ADJ_COARSE_LSB];
        fine_r   <= hwdata_in[`DACS_ADJ_FINE_MSB:`DACS_ADJ_FINE_LSB];
        lc_r     <= hwdata_in[`DACS_ADJ_LC_MSB:`DACS_ADJ_LC_LSB];
      end
      if (wr_syn) begin
        dr_r       <= hwdata_in[`DACS_SYN_DR];
        doc_r      <= hwdata_in[`DACS_SYN_DOC];
        es_r       <= hwdata_in[`DACS_SYN_ES];
        phase_r    <= hwdata_in[`DACS_SYN_PH_MSB:`DACS_SYN_PH_LSB];
        dly_code_r <= hwdata_in[`DACS_SYN_DLY_MSB:`DACS_SYN_DLY_LSB];
      end
    end
  end

  // A full-scale change flags a pending recalibration; a new change wins over the clearing command.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cal_req_r           <= 1'b0;
      calibrate_start_out <= 1'b0;
    end else begin
      calibrate_start_out <= wr_cmd & hwdata_in[`DACS_CMD_CAL];
      if ((wr_ich & (fs_i_nxt != fs_i_r)) | (wr_qch & (fs_q_nxt != fs_q_r))) begin
        cal_req_r <= 1'b1;
      end else if (wr_cmd & hwdata_in[`DACS_CMD_CAL]) begin
        cal_req_r <= 1'b0;
      end
    end
  end

  // Three-stage pin synchroniser; a level counts only once stages two and three agree.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1_r        <= 12'h000;
      pin_s2_r        <= 12'h000;
      pin_s3_r        <= 12'h000;
      pin_stable_r    <= 12'h000;
      data_output_clock_rst_prev_r <= 1'b0;
    end else begin
      pin_s1_r        <= {extended_control_enable_in, data_output_clock_reset_in, control_pins_in};
      pin_s2_r        <= pin_s1_r;
      pin_s3_r        <= pin_s2_r;
      pin_stable_r    <= (pin_s2_r & pin_s3_r) | (pin_stable_r & (pin_s2_r | pin_s3_r));
      data_output_clock_rst_prev_r <= data_output_clock_rst_sync;
    end
  end

  // Output format and front-end controls follow the effective configuration.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_clock_phase_select_out <= 1'b0;
      output_swing_select_out     <= 1'b0;
      fixed_pattern_mode_out      <= 1'b0;
      i_channel_powerdown_out     <= 1'b0;
      q_channel_powerdown_out     <= 1'b0;
      double_edge_sampling_out    <= 1'b0;
      interleave_from_q_input_out <= 1'b0;
      interleave_inputs_tied_out  <= 1'b0;
      data_output_clock_reset_out <= 1'b0;
    end else begin
      // Non-demultiplexed mode has no second phase, so the phase bit is forced to zero degrees.
      data_clock_phase_select_out <= eff_cfg[`DACS_CFG_PHASE] & ~eff_cfg[`DACS_CFG_NON_DEMUX];
      output_swing_select_out     <= eff_cfg[`DACS_CFG_SWING];
      fixed_pattern_mode_out      <= eff_cfg[`DACS_CFG_PATTERN];
      i_channel_powerdown_out     <= eff_cfg[`DACS_CFG_PD_I];
      q_channel_powerdown_out     <= eff_cfg[`DACS_CFG_PD_Q];
      double_edge_sampling_out    <= eff_cfg[`DACS_CFG_DES];
      interleave_from_q_input_out <= eff_cfg[`DACS_CFG_DES] & eff_cfg[`DACS_CFG_DES_Q];
      interleave_inputs_tied_out  <= eff_cfg[`DACS_CFG_DES] & eff_cfg[`DACS_CFG_DES_TIED];
      // One pulse per rising edge of the external reset, unless it is disabled.
      data_output_clock_reset_out <= data_output_clock_rst_sync & ~data_output_clock_rst_prev_r & ~dr_r;
    end
  end

  // Sample path: pattern overrides conversion data, coding flips the sign bit for two's complement.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_i_out      <= 10'h000;
      overrange_i_out <= 1'b0;
      data_q_out      <= 10'h000;
      overrange_q_out <= 1'b0;
    end else if (eff_cfg[`DACS_CFG_PATTERN]) begin
      data_i_out      <= PATTERN_I;
      overrange_i_out <= 1'b1;
      data_q_out      <= PATTERN_Q;
      overrange_q_out <= 1'b0;
    end else begin
      data_i_out      <= eff_cfg[`DACS_CFG_PD_I] ? 10'h000 :
                         {sample_i_in[9] ^ eff_cfg[`DACS_CFG_TWOS], sample_i_in[8:0]};
      overrange_i_out <= overrange_i_in & ~eff_cfg[`DACS_CFG_PD_I];
      data_q_out      <= eff_cfg[`DACS_CFG_PD_Q] ? 10'h000 :
                         {sample_q_in[9] ^ eff_cfg[`DACS_CFG_TWOS], sample_q_in[8:0]};
      overrange_q_out <= overrange_q_in & ~eff_cfg[`DACS_CFG_PD_Q];
    end
  end

  // Channel offset and range settings driven to the analog core.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      offset_i_out          <= 10'h000;
      offset_i_negative_out <= 1'b0;
      offset_q_out          <= 10'h000;
      offset_q_negative_out <= 1'b0;
      full_scale_i_mv_out   <= `DACS_FS_RESET_MV;
      full_scale_q_mv_out   <= `DACS_FS_RESET_MV;
    end else begin
      offset_i_out          <= ofs_i_r;
      offset_i_negative_out <= sign_i_r;
      offset_q_out          <= ofs_q_r;
      offset_q_negative_out <= sign_q_r;
      full_scale_i_mv_out   <= fs_i_r;
      full_scale_q_mv_out   <= fs_q_r;
    end
  end

  // Clock tuning: the filter-delay bit overrides the plain delay enable.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      duty_cycle_correction_out <= 1'b1;
      aperture_delay_enable_out <= 1'b0;
      aperture_delay_out        <= 9'h000;
      lc_filter_enable_out      <= 1'b0;
      lc_filter_tune_out        <= 4'h0;
    end else begin
      duty_cycle_correction_out <= dcc_r;
      aperture_delay_enable_out <= sta_r | sa_r;
      // Delay reads zero while adjustment is off, so the core never applies a stale sum.
      aperture_delay_out        <= (sta_r | sa_r) ? ({4'h0, coarse_r} + {1'b0, fine_r}) : 9'h000;
      lc_filter_enable_out      <= sa_r;
      lc_filter_tune_out        <= sa_r ? lc_r : 4'h0;
    end
  end

  // Quarter-rate divider for the reference outputs.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  // Synchronisation outputs.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reference_clock_out_a     <= 1'b0;
      reference_clock_out_b     <= 1'b0;
      follower_sync_mode_out    <= 1'b0;
      follower_phase_select_out <= 2'h0;
      reference_delay_ps_out    <= 10'h000;
    end else begin
      reference_clock_out_a     <= ~doc_r & div_r[1];
      reference_clock_out_b     <= ~doc_r & div_r[1];
      follower_sync_mode_out    <= es_r;
      follower_phase_select_out <= es_r ? phase_r : 2'h0;
      reference_delay_ps_out    <= dly_ps[9:0];
    end
  end

endmodule // dacs_top

// file: test/dacs_top_sva.sv
// Concurrent checks on the output side of the dual converter settings block.
`timescale 1ns/1ps
module dacs_top_sva #(
  parameter [9:0] PATTERN_I = 10'h2AA,
  parameter [9:0] PATTERN_Q = 10'h155
) (
  // Clock and reset.
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  // Sample path.
  input wire logic [9:0] data_i_out,
  input wire logic       overrange_i_out,
  input wire logic [9:0] data_q_out,
  input wire logic       overrange_q_out,
  input wire logic       fixed_pattern_mode_out,
  input wire logic       i_channel_powerdown_out,
  // Front end and clock tuning.
  input wire logic       double_edge_sampling_out,
  input wire logic       interleave_from_q_input_out,
  input wire logic       aperture_delay_enable_out,
  input wire logic [8:0] aperture_delay_out,
  input wire logic       lc_filter_enable_out,
  // Synchronisation.
  input wire logic       reference_clock_out_a,
  input wire logic       reference_clock_out_b,
  input wire logic       follower_sync_mode_out,
  input wire logic [1:0] follower_phase_select_out,
  input wire logic [9:0] reference_delay_ps_out
);
  // One clock domain, so clock and reset are given once for every check.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Three steady cycles let the sample register catch up with a mode change.
  property p_pattern;
    fixed_pattern_mode_out [*3] |-> data_i_out == PATTERN_I && overrange_i_out && data_q_out == PATTERN_Q
      && !overrange_q_out;
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern values wrong");
  property p_pd_i;
    (i_channel_powerdown_out && !fixed_pattern_mode_out) [*3] |-> data_i_out == 10'h000;
  endproperty
  a_pd_i: assert property (p_pd_i) else $error("powered down channel not zero");
  property p_from_q;
    interleave_from_q_input_out |-> double_edge_sampling_out;
  endproperty
  a_from_q: assert property (p_from_q) else $error("q input chosen outside interleave");
  property p_delay_off;
    !aperture_delay_enable_out |-> aperture_delay_out == 9'h000;
  endproperty
  a_delay_off: assert property (p_delay_off) else $error("delay applied while disabled");
  property p_filter;
    lc_filter_enable_out |-> aperture_delay_enable_out;
  endproperty
  a_filter: assert property (p_filter) else $error("filter on without delay adjust");
  // A rising edge must follow at least two low cycles, and both outputs move together.
  property p_ref_clk;
    reference_clock_out_a == reference_clock_out_b && (!$rose(reference_clock_out_a) || !$past(reference_clock_out_a, 2));
  endproperty
  a_ref_clk: assert property (p_ref_clk) else $error("reference clocks wrong");
  property p_follower;
    !follower_sync_mode_out |-> follower_phase_select_out == 2'b00;
  endproperty
  a_follower: assert property (p_follower) else $error("phase chosen outside follower mode");
  property p_delay_sat;
    reference_delay_ps_out <= 10'd1000;
  endproperty
  a_delay_sat: assert property (p_delay_sat) else $error("reference delay above maximum");
endmodule // dacs_top_sva

// file: test/dacs_host.sv
// Bus master model of the host that programs the settings block.
`timescale 1ns/1ps
module dacs_host (
  // Clock and bus answer.
  input  wire logic        clk_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_in,
  // Bus request.
  output logic             hsel_out,
  output logic [11:0]      haddr_out,
  output logic [1:0]       htrans_out,
  output logic             hwrite_out,
  output logic [2:0]       hsize_out,
  output logic [31:0]      hwdata_out
);
  int timeouts = 0;

  // Idle bus from time zero.
  initial begin
    hsel_out = 1'b0;
    haddr_out = 12'h000;
    htrans_out = 2'b00;
    hwrite_out = 1'b0;
    hsize_out = 3'b010;
    hwdata_out = 32'h0000_0000;
  end

  // Bounded wait for hready; a slave that never answers is counted, not waited on forever.
  task automatic wait_ready();
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (hready_in === 1'b1) break;
    end
    if (n == 50) timeouts++;
  endtask

  // One single word transfer, called just after a rising edge.
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    hsel_out <= 1'b1;
    haddr_out <= a;
    htrans_out <= 2'b10;
    hwrite_out <= w;
    wait_ready();
    htrans_out <= 2'b00;
    hwdata_out <= d;
    wait_ready();
    q = hrdata_in;
    // Released data shows the inverse so a stale word cannot pass as fresh.
    hwdata_out <= ~d;
  endtask
endmodule // dacs_host

// file: test/test_dual_adc_control_settings.sv
// Self-checking bench for the dual converter settings block.
`timescale 1ns/1ps
module test_dual_adc_control_settings;
  localparam [9:0] PAT_I = 10'h2AA;
  localparam [9:0] PAT_Q = 10'h155;
  logic        clk_in, rst_b_in, hsel_in, hwrite_in, hready_in, extended_control_enable_in;
  logic        data_output_clock_reset_in, overrange_i_in, overrange_q_in, hreadyout_out, hresp_out;
  logic [11:0] haddr_in;
  logic [1:0]  htrans_in, follower_phase_select_out;
  logic [2:0]  hsize_in;
  logic [31:0] hwdata_in, hrdata_out;
  logic [9:0]  control_pins_in, sample_i_in, sample_q_in, data_i_out, data_q_out, offset_i_out, offset_q_out;
  logic [9:0]  full_scale_i_mv_out, full_scale_q_mv_out, reference_delay_ps_out;
  logic        overrange_i_out, overrange_q_out, data_clock_phase_select_out, output_swing_select_out;
  logic        fixed_pattern_mode_out, data_output_clock_reset_out, i_channel_powerdown_out;
  logic        q_channel_powerdown_out, double_edge_sampling_out, interleave_from_q_input_out;
  logic        interleave_inputs_tied_out, offset_i_negative_out, offset_q_negative_out, calibrate_start_out;
  logic        duty_cycle_correction_out, aperture_delay_enable_out, lc_filter_enable_out;
  logic        reference_clock_out_a, reference_clock_out_b, follower_sync_mode_out;
  logic [8:0]  aperture_delay_out;
  logic [3:0]  lc_filter_tune_out;
  int          failures = 0;
  int          num_checks = 0;
  int          n;
  logic [31:0] q;
  logic [9:0]  cfg [9] = '{10'h001, 10'h201, 10'h002, 10'h004, 10'h008, 10'h010, 10'h060, 10'h040, 10'h0A0};
  logic [31:0] adj [3] = '{32'h300A_0502, 32'h30FF_1F05, 32'h30FF_1F00};
  logic [15:0] adj_exp [3] = '{{2'b01, 9'd15, 5'h00}, {2'b11, 9'd286, 5'h13}, 16'h0000};
  logic [9:0]  codes [5] = '{10'd0, 10'd320, 10'd639, 10'd640, 10'd1023};

  assign hready_in = hreadyout_out;
  dacs_top #(.PATTERN_I(PAT_I), .PATTERN_Q(PAT_Q)) dacs_top_inst (.*);
  dacs_host dacs_host_inst (.clk_in(clk_in), .hready_in(hready_in), .hrdata_in(hrdata_out), .hsel_out(hsel_in),
    .haddr_out(haddr_in), .htrans_out(htrans_in), .hwrite_out(hwrite_in), .hsize_out(hsize_in),
    .hwdata_out(hwdata_in));

  // Free-running 25 MHz clock.
  always #20 clk_in = ~clk_in;

  // Compare and count; unknowns never match.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Write, then let the settings reach the outputs before anything is sampled.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    dacs_host_inst.xfer(a, 1'b1, d, q);
    repeat (2) @(posedge clk_in);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    dacs_host_inst.xfer(a, 1'b0, 32'h0000_0000, q);
    chk(q, e);
  endtask

  // Counts the cycles in which a one-bit output is high over a fixed span.
  task automatic count_high(ref logic s, input int span);
    n = 0;
    repeat (span) begin
      @(posedge clk_in);
      n += s;
    end
  endtask

  task automatic complete_run();
    failures += dacs_host_inst.timeouts;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence; extended control is strapped on from time zero.
  initial begin
    clk_in = 1'b0;
    rst_b_in = 1'b0;
    extended_control_enable_in = 1'b1;
    data_output_clock_reset_in = 1'b0;
    control_pins_in = 10'h000;
    sample_i_in = 10'h123;
    sample_q_in = 10'h0AB;
    overrange_i_in = 1'b1;
    overrange_q_in = 1'b0;
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk({20'h0, hresp_out, duty_cycle_correction_out, full_scale_i_mv_out}, {20'h0, 1'b0, 1'b1, 10'd790});
    rchk(12'h000, 32'h0000_0000);
    rchk(12'h004, 32'h0316_0000);
    rchk(12'h00C, 32'h0000_0001);
    rchk(12'h010, 32'h0000_0003);
    rchk(12'h020, 32'h0000_0000);
    $display("reset test done");
    foreach (cfg[k]) begin
      wr(12'h000, {22'h0, cfg[k]});
      chk({data_clock_phase_select_out, output_swing_select_out, fixed_pattern_mode_out, i_channel_powerdown_out,
        q_channel_powerdown_out, double_edge_sampling_out, interleave_from_q_input_out, interleave_inputs_tied_out},
        {cfg[k][0] & ~cfg[k][9], cfg[k][1], cfg[k][2], cfg[k][3], cfg[k][4], cfg[k][5], cfg[k][6] & cfg[k][5],
        cfg[k][7] & cfg[k][5]});
    end
    for (int t = 1; t >= 0; t--) begin
      wr(12'h000, {23'h0, t[0], 8'h00});
      chk({overrange_q_out, overrange_i_out, data_q_out, data_i_out},
        {2'b01, 10'h0AB ^ {t[0], 9'h0}, 10'h123 ^ {t[0], 9'h0}});
    end
    $display("config test done");
    wr(12'h004, 32'h03E8_0555);
    chk({offset_i_negative_out, offset_i_out, full_scale_i_mv_out}, {1'b1, 10'h155, 10'd980});
    rchk(12'h018, 32'h0000_0003);
    wr(12'h014, 32'h0000_0001);
    rchk(12'h018, 32'h0000_0002);
    wr(12'h008, 32'h01F4_0000);
    chk({offset_q_negative_out, offset_q_out, full_scale_q_mv_out, offset_i_out}, {1'b0, 10'h0, 10'd600, 10'h155});
    // The start pulse stands one cycle only, so it is counted straight after the data phase.
    dacs_host_inst.xfer(12'h014, 1'b1, 32'h0000_0001, q);
    count_high(calibrate_start_out, 4);
    chk(n, 1);
    $display("channel test done");
    foreach (adj[k]) begin
      wr(12'h00C, adj[k]);
      chk({duty_cycle_correction_out, aperture_delay_enable_out, aperture_delay_out, lc_filter_enable_out,
        lc_filter_tune_out}, adj_exp[k]);
    end
    $display("adjust test done");
    foreach (codes[k]) begin
      wr(12'h010, {6'h0, codes[k], 16'h0025});
      chk({follower_sync_mode_out, follower_phase_select_out, reference_delay_ps_out},
        {1'b1, 2'd2, 10'((codes[k] > 639 ? 639 : codes[k]) * 1000 / 639)});
    end
    count_high(reference_clock_out_a, 8);
    chk(n, 4);
    wr(12'h010, 32'h0000_0033);
    count_high(reference_clock_out_a, 8);
    chk({n[28:0], follower_sync_mode_out, follower_phase_select_out}, 32'h0);
    for (int d = 0; d < 2; d++) begin
      wr(12'h010, {30'h0, 1'b1, d[0]});
      data_output_clock_reset_in <= 1'b1;
      count_high(data_output_clock_reset_out, 12);
      data_output_clock_reset_in <= 1'b0;
      chk(n, 1 - d);
      repeat (6) @(posedge clk_in);
    end
    $display("sync test done");
    // Pin mode: the config bits come from the pins until extended control returns.
    control_pins_in <= 10'h004;
    extended_control_enable_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk(fixed_pattern_mode_out, 1'b1);
    extended_control_enable_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk(fixed_pattern_mode_out, 1'b0);
    $display("pin mode test done");
    complete_run();
  end
endmodule // test_dual_adc_control_settings

bind dacs_top dacs_top_sva #(.PATTERN_I(PATTERN_I), .PATTERN_Q(PATTERN_Q)) dacs_top_sva_inst (.*);
